// file: rtl/spe_pins.v
`timescale 1ns/10ps
`default_nettype none
`include "spe_map.vh"

// Small synchronous FIFO; full and empty come straight from the count
module spe_fifo #(
  parameter W  = 9,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire         i_clk,    // Core clock
  input  wire         i_rst,    // Sync reset, high
  input  wire         i_valid,  // Write request
  output wire         o_ready,  // Space available
  input  wire [W-1:0] i_data,   // Write data
  output wire         o_valid,  // Data available
  input  wire         i_ready,  // Reader takes word
  output wire [W-1:0] o_data    // Head word
);
  reg [W-1:0]  mem_q [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0]   cnt_q;
  wire         push;
  wire         pop;

  // Handshakes on both sides
  assign o_ready = (cnt_q != D[AW:0]);
  assign o_valid = (cnt_q != {(AW+1){1'b0}});
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem_q[rd_q];

  // Storage, not reset: data only counts once written
  always @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  // Pointers wrap to zero after D-1, so D need not be a power of two
  always @(posedge i_clk) begin
    if (i_rst) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// Pin-level serial front end, oversampling the serial clock
module spe_pins #(
  parameter WR_CYCLES  = `SPE_WR_CYCLES,
  parameter FIFO_DEPTH = `SPE_FIFO_DEPTH,
  parameter FIFO_AW    = `SPE_FIFO_AW
) (
  input  wire       i_clk,          // Core clock, 100 MHz
  input  wire       i_rst,          // Sync reset, high
  input  wire       i_cs_n,         // Chip select pin, low active
  input  wire       i_sck,          // Serial clock pin
  input  wire       i_si,           // Serial data in pin
  input  wire       i_guard_n,      // Write-guard pin, low active
  input  wire       i_pause_n,      // Pause pin, low active
  output wire       o_so,           // Serial data out
  output wire       o_so_oe,        // Serial out enable
  output wire       o_rx_valid,     // Received byte ready
  output wire [7:0] o_rx_data,      // Received byte
  output wire       o_rx_first,     // Byte is an opcode
  input  wire       i_rx_ready,     // User takes byte
  output wire       o_rx_drop,      // Byte lost to full FIFO
  input  wire [7:0] i_tx_data,      // Read data from array
  output wire       o_tx_take,      // Pulse: i_tx_data used
  output wire [7:0] o_status,       // Status register
  output wire       o_write_busy,   // Self-timed cycle running
  output wire [1:0] o_protect_span  // 0 none,1 quarter,2 half,3 all
);
  reg [`SPE_SYNC_W-1:0] sync1_q;
  reg [`SPE_SYNC_W-1:0] sync2_q;
  reg                   sck_prev_q;
  reg                   guard_prev_q;
  reg                   sel_prev_q;
  reg                   armed_q;
  reg  [7:0]            sh_q;
  reg  [2:0]            bit_q;
  reg  [1:0]            idx_q;
  reg  [7:0]            op_q;
  reg                   out_act_q;
  reg  [7:0]            tx_sh_q;
  reg                   so_q;
  reg                   oe_q;
  reg                   take_q;
  reg  [7:0]            pend_q;
  reg                   pend_v_q;
  reg                   guard_en_q;
  reg  [1:0]            prot_q;
  reg                   busy_q;
  reg  [`SPE_WR_CW-1:0] wr_cnt_q;
  reg                   drop_q;
  reg                   abort_q;
  wire                  cs_n_s;
  wire                  sck_s;
  wire                  si_s;
  wire                  guard_n_s;
  wire                  pause_n_s;
  wire                  sel;
  wire                  paused;
  wire                  rise;
  wire                  fall;
  wire [7:0]            rx_byte;
  wire                  byte_end;
  wire [7:0]            op_now;
  wire                  stat_op;
  wire                  guarded;
  wire                  push_v;
  wire                  push_rdy;
  wire [7:0]            status;
  wire [`SPE_FIFO_W-1:0] fifo_out;
  // Reset image of the status byte; fields are cut from it below
  localparam [7:0] ST_RST = `SPE_ST_RESET;

  // Two flops on every pin before any logic looks at it
  // Reset to idle pin levels so no false clock edge follows reset
  always @(posedge i_clk) begin
    if (i_rst) begin
      sync1_q <= `SPE_SYNC_RESET;
      sync2_q <= `SPE_SYNC_RESET;
    end else begin
      sync1_q <= {i_pause_n, i_guard_n, i_si, i_sck, i_cs_n};
      sync2_q <= sync1_q;
    end
  end

  // Synchronised pin levels
  assign cs_n_s    = sync2_q[`SPE_IX_CS];
  assign sck_s     = sync2_q[`SPE_IX_SCK];
  assign si_s      = sync2_q[`SPE_IX_SI];
  assign guard_n_s = sync2_q[`SPE_IX_GUARD];
  assign pause_n_s = sync2_q[`SPE_IX_PAUSE];

  // Selection and clock edge detection
  // Edges come from the synced clock, so the link must stay well below core rate
  assign sel     = armed_q & ~cs_n_s;
  assign paused  = ~pause_n_s;
  assign rise    = sel & ~paused & sck_s & ~sck_prev_q;
  assign fall    = sel & ~paused & ~sck_s & sck_prev_q;
  assign rx_byte = {sh_q[6:0], si_s};
  assign byte_end = rise & (bit_q == 3'h7);
  assign op_now  = (idx_q == 2'h0) ? rx_byte : op_q;
  assign stat_op = (op_now == `SPE_OP_RD_STAT) | (op_now == `SPE_OP_WR_STAT);
  // Pin counts only when the enable bit is set
  assign guarded = guard_en_q & ~guard_n_s;

  // Memory-path bytes go to the FIFO; read phase input is not data
  assign push_v = byte_end & ~stat_op & ~out_act_q;

  // Status byte as read back over the link
  assign status = {guard_en_q, 3'h0, prot_q, 1'b0, busy_q};

  // Previous levels for edge detection, sampled every cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      sck_prev_q   <= 1'b0;
      guard_prev_q <= 1'b1;
      sel_prev_q   <= 1'b0;
    end else begin
      sck_prev_q   <= sck_s;
      guard_prev_q <= guard_n_s;
      sel_prev_q   <= sel;
    end
  end

  // Armed by the first low chip select seen after reset
  always @(posedge i_clk) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (~cs_n_s) begin
      armed_q <= 1'b1;
    end
  end

  // Input shifter; deselect clears the sequence, pause only freezes it
  always @(posedge i_clk) begin
    if (i_rst) begin
      sh_q  <= 8'h00;
      bit_q <= 3'h0;
      idx_q <= 2'h0;
      op_q  <= 8'h00;
    end else if (~sel) begin
      bit_q <= 3'h0;
      idx_q <= 2'h0;
    end else if (rise) begin
      sh_q  <= rx_byte;
      bit_q <= bit_q + 3'h1;
      if (byte_end) begin
        if (idx_q == 2'h0) begin
          op_q <= rx_byte;
        end
        if (idx_q != 2'h3) begin
          idx_q <= idx_q + 2'h1;
        end
      end
    end
  end

  // Output phase: loaded at a byte end, shifted on falling edges
  always @(posedge i_clk) begin
    if (i_rst) begin
      out_act_q <= 1'b0;
      tx_sh_q   <= 8'h00;
      so_q      <= 1'b0;
      take_q    <= 1'b0;
    end else begin
      take_q <= 1'b0;
      if (~sel) begin
        out_act_q <= 1'b0;
      end else if (byte_end) begin
        if (op_now == `SPE_OP_RD_STAT) begin
          out_act_q <= 1'b1;
          tx_sh_q   <= status;
        end else if ((op_now == `SPE_OP_RD_DATA) &&
                     (out_act_q || idx_q == `SPE_RD_ADDR_IX)) begin
          out_act_q <= 1'b1;
          tx_sh_q   <= i_tx_data;
          take_q    <= 1'b1;
        end
      end else if (fall && out_act_q) begin
        so_q    <= tx_sh_q[7];
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // Drive only when selected, running and in the output phase
  always @(posedge i_clk) begin
    if (i_rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= sel & ~paused & out_act_q;
    end
  end

  // Sticky for the whole frame: a guard that falls and rises again
  // before the value byte must not let a later byte end re-arm the write
  always @(posedge i_clk) begin
    if (i_rst) begin
      abort_q <= 1'b0;
    end else if (~sel) begin
      abort_q <= 1'b0;
    end else if (guard_en_q && guard_prev_q && ~guard_n_s) begin
      abort_q <= 1'b1;
    end
  end

  // Pending status write; a guard fall mid-command cancels it
  always @(posedge i_clk) begin
    if (i_rst) begin
      pend_q   <= 8'h00;
      pend_v_q <= 1'b0;
    end else if (~sel) begin
      pend_v_q <= 1'b0;
    end else if (guard_en_q && guard_prev_q && ~guard_n_s &&
                 op_q == `SPE_OP_WR_STAT) begin
      pend_v_q <= 1'b0;
    end else if (byte_end && idx_q == 2'h1 && op_q == `SPE_OP_WR_STAT) begin
      pend_q   <= rx_byte;
      pend_v_q <= ~guarded & ~busy_q & ~abort_q;
    end
  end

  // Commit at deselect, then run the self-timed cycle to its end
  // The new value shows at once; busy alone marks the timed cycle
  always @(posedge i_clk) begin
    if (i_rst) begin
      guard_en_q <= ST_RST[`SPE_ST_GUARD_EN];
      prot_q     <= ST_RST[`SPE_ST_PROT_HI:`SPE_ST_PROT_LO];
      busy_q     <= 1'b0;
      wr_cnt_q   <= {`SPE_WR_CW{1'b0}};
    end else if (busy_q) begin
      // Guard pin is not looked at here once started
      if (wr_cnt_q == WR_CYCLES[`SPE_WR_CW-1:0] - 1'b1) begin
        busy_q <= 1'b0;
      end
      wr_cnt_q <= wr_cnt_q + 1'b1;
    end else if (sel_prev_q && ~sel && pend_v_q && ~guarded) begin
      guard_en_q <= pend_q[`SPE_ST_GUARD_EN];
      prot_q     <= pend_q[`SPE_ST_PROT_HI:`SPE_ST_PROT_LO];
      busy_q     <= 1'b1;
      wr_cnt_q   <= {`SPE_WR_CW{1'b0}};
    end
  end

  // Overrun flag: a new select clears it, a drop in that cycle wins
  always @(posedge i_clk) begin
    if (i_rst) begin
      drop_q <= 1'b0;
    end else if (push_v & ~push_rdy) begin
      drop_q <= 1'b1;
    end else if (sel & ~sel_prev_q) begin
      drop_q <= 1'b0;
    end
  end

  // The serial link cannot stall, so a full FIFO drops the byte
  spe_fifo #(
    .W  (`SPE_FIFO_W),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_valid (push_v),
    .o_ready (push_rdy),
    .i_data  ({(idx_q == 2'h0), rx_byte}),
    .o_valid (o_rx_valid),
    .i_ready (i_rx_ready),
    .o_data  (fifo_out)
  );

  // Outputs, all from flops or the FIFO head
  assign o_rx_data      = fifo_out[7:0];
  assign o_rx_first     = fifo_out[8];
  assign o_rx_drop      = drop_q;
  assign o_so           = so_q;
  assign o_so_oe        = oe_q;
  assign o_tx_take      = take_q;
  assign o_status       = status;
  assign o_write_busy   = busy_q;
  assign o_protect_span = prot_q;
endmodule

`default_nettype wire

// file: rtl/spe_map.vh
`ifndef SPE_MAP_VH
`define SPE_MAP_VH

// Clock and write cycle timing
`define SPE_CLK_KHZ     100000
`define SPE_WR_TIME_MS  5
`define SPE_WR_CYCLES   (`SPE_WR_TIME_MS * `SPE_CLK_KHZ)
`define SPE_WR_CW       20

// Opcodes handled here; all but the two status opcodes go to the byte FIFO
`define SPE_OP_RD_STAT  8'h05
`define SPE_OP_WR_STAT  8'h01
`define SPE_OP_RD_DATA  8'h03
`define SPE_RD_ADDR_IX  2'h2

// Status register fields
`define SPE_ST_GUARD_EN 7
`define SPE_ST_PROT_HI  3
`define SPE_ST_PROT_LO  2
`define SPE_ST_BUSY     0
`define SPE_ST_RESET    8'h00

// Synchroniser lane positions
`define SPE_IX_CS       0
`define SPE_IX_SCK      1
`define SPE_IX_SI       2
`define SPE_IX_GUARD    3
`define SPE_IX_PAUSE    4
`define SPE_SYNC_W      5
`define SPE_SYNC_RESET  5'h19

// Byte FIFO shape
`define SPE_FIFO_W      9
`define SPE_FIFO_DEPTH  8
`define SPE_FIFO_AW     3

`endif

// file: bench/spe_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the serial front end
module spe_asserts #(
  parameter WR_CYCLES = 20
) (
  input wire logic       i_clk,          // Core clock
  input wire logic       i_rst,          // Sync reset
  input wire logic       i_cs_n,         // Chip select pin
  input wire logic       i_pause_n,      // Pause pin
  input wire logic       i_guard_n,      // Write-guard pin
  input wire logic       o_so_oe,        // Output enable
  input wire logic       o_rx_drop,      // Lost byte flag
  input wire logic       o_tx_take,      // Read data used
  input wire logic [7:0] o_status,       // Status register
  input wire logic       o_write_busy,   // Timed write
  input wire logic [1:0] o_protect_span  // Protected span
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  logic [19:0] busy_cnt_q;
  // Length of the timed write, zero between writes
  always_ff @(posedge i_clk) busy_cnt_q <= o_write_busy ? busy_cnt_q + 20'h1 : 20'h0;
  desel_float_a: assert property (i_cs_n [*5] |-> !o_so_oe)
    else $error("output driven while deselected");
  pause_float_a: assert property (!i_pause_n [*5] |-> !o_so_oe)
    else $error("output driven while paused");
  drive_sel_a: assert property ($rose(o_so_oe) |-> !i_cs_n && i_pause_n)
    else $error("output enabled outside a selected frame");
  desel_hold_a: assert property (i_cs_n [*6] |-> $stable({o_status[7:1], o_rx_drop}))
    else $error("state moved while deselected");
  // Six cycles cover the pin synchroniser delay
  guard_block_a: assert property ((!i_guard_n && o_status[7]) [*6] |-> $stable(o_status[7:1]))
    else $error("status written while guarded");
  span_map_a: assert property (o_protect_span == o_status[3:2])
    else $error("span differs from status field");
  busy_bit_a: assert property (o_write_busy == o_status[0])
    else $error("busy bit differs from busy flag");
  busy_len_a: assert property (o_write_busy |-> busy_cnt_q < WR_CYCLES + 1)
    else $error("timed write too long");
  busy_full_a: assert property ($fell(o_write_busy) |-> $past(busy_cnt_q) == WR_CYCLES - 1)
    else $error("timed write cut short");
  take_pulse_a: assert property (o_tx_take |=> !o_tx_take)
    else $error("take pulse longer than one cycle");
  cover property ($rose(o_write_busy));
  cover property ($rose(o_so_oe));
  cover property (o_tx_take);
  cover property ($rose(o_rx_drop));
endmodule
bind spe_pins spe_asserts #(.WR_CYCLES(WR_CYCLES)) u_asserts (.i_clk, .i_rst, .i_cs_n,
  .i_pause_n, .i_guard_n, .o_so_oe, .o_rx_drop, .o_tx_take, .o_status, .o_write_busy,
  .o_protect_span);
`default_nettype wire

// file: bench/spe_master.sv
`timescale 1ns/10ps
`default_nettype none
// Serial bus master; pins move only right after core clock edges
module spe_master (
  input  wire logic i_clk,     // Core clock
  input  wire logic i_so,      // Resolved serial out
  output var  logic o_cs_n,    // Chip select
  output var  logic o_sck,     // Serial clock
  output var  logic o_si,      // Serial data
  output var  logic o_pause_n  // Pause
);
  logic h;
  // Deselected, clock idle low
  initial {o_cs_n, o_sck, o_si, o_pause_n, h} = 5'h12;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // Mode 0, MSB first; high half alternates so the period averages 125 ns
  task automatic shift(input int n, input logic [7:0] v, output logic [7:0] r);
    for (int i = n - 1; i >= 0; i--) begin
      o_si <= v[i];
      tick(6);
      o_sck <= 1'b1;
      r = {r[6:0], i_so};
      h = ~h;
      tick(6 + h);
      o_sck <= 1'b0;
    end
  endtask
  // Select edge with SCK low; SI left unsettled between frames
  task automatic cs(input logic v);
    o_cs_n <= v;
    o_si <= ~o_si;
    tick(8);
  endtask
  // Let the last clock fall settle before moving pause
  task automatic pause(input logic v);
    tick(4);
    o_pause_n <= v;
    tick(4);
  endtask
endmodule
`default_nettype wire

// file: bench/spi_eeprom_pin_interface_test.sv
`timescale 1ns/10ps
`default_nettype none
module spi_eeprom_pin_interface_test;
  localparam int WR = 20;
  logic       clk = 1'b0;
  logic       rst;
  logic       guard_n;
  logic       rx_ready;
  logic [7:0] tx_data;
  logic [7:0] r;
  int         n_errors = 0;
  int         check_count = 0;
  int         takes = 0;
  wire        cs_n, sck, si, pause_n, so, so_oe, rx_valid, rx_first, rx_drop, tx_take, busy;
  wire  [7:0] rx_data, status;
  wire  [1:0] span;
  wire        so_w = so_oe ? so : 1'bz;
  spe_pins #(.WR_CYCLES(WR)) u_dut (.i_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_sck(sck),
    .i_si(si), .i_guard_n(guard_n), .i_pause_n(pause_n), .o_so(so), .o_so_oe(so_oe),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .o_rx_first(rx_first),
    .i_rx_ready(rx_ready), .o_rx_drop(rx_drop), .i_tx_data(tx_data), .o_tx_take(tx_take),
    .o_status(status), .o_write_busy(busy), .o_protect_span(span));
  spe_master u_m (.i_clk(clk), .i_so(so_w), .o_cs_n(cs_n), .o_sck(sck), .o_si(si),
    .o_pause_n(pause_n));
  always #5 clk = ~clk;
  // Count read data fetches; each fetch moves the array byte on
  always @(posedge clk) begin
    if (rst) begin
      tx_data <= 8'h5a;
    end else if (tx_take === 1'b1) begin
      tx_data <= tx_data + 8'h11;
      takes++;
    end
  end
  task automatic chk(input logic [8:0] s, e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic frame(input logic [7:0] op, d, input int nb);
    u_m.cs(1'b0);
    u_m.shift(8, op, r);
    repeat (nb) u_m.shift(8, d, r);
    u_m.cs(1'b1);
  endtask
  // Head byte with its opcode flag, then pop it
  task automatic pop(input logic [8:0] e);
    chk({8'h0, rx_valid}, 9'h001);
    chk({rx_first, rx_data}, e);
    rx_ready <= 1'b1;
    cyc(1);
    rx_ready <= 1'b0;
    cyc(1);
  endtask
  // Status write; guard before the opcode, over the value's upper half, in the timed cycle
  task automatic wr(input logic [7:0] v, input logic g0, g1, g2, input logic [7:0] e);
    guard_n <= g0;
    u_m.cs(1'b0);
    u_m.shift(8, 8'h01, r);
    guard_n <= g1;
    u_m.shift(4, v >> 4, r);
    guard_n <= g0;
    u_m.shift(4, v, r);
    u_m.cs(1'b1);
    guard_n <= g2;
    chk({1'b0, status[7:1], 1'b0}, {1'b0, e[7:1], 1'b0});
    chk({8'h0, busy}, {8'h0, v == e});
    cyc(WR);
    chk({8'h0, busy}, 9'h000);
  endtask
  task automatic t_desel;
    u_m.shift(8, 8'h3c, r);
    chk({8'h0, rx_valid}, 9'h000);
    chk({8'h0, so_w}, {8'h0, 1'bz});
  endtask
  task automatic t_status;
    wr(8'h84, 1'b0, 1'b0, 1'b0, 8'h84);
    wr(8'h00, 1'b0, 1'b0, 1'b1, 8'h84);
    wr(8'h88, 1'b1, 1'b1, 1'b1, 8'h88);
    wr(8'h8c, 1'b1, 1'b0, 1'b1, 8'h88);
    wr(8'h8c, 1'b1, 1'b1, 1'b0, 8'h8c);
    chk({7'h0, span}, 9'h003);
    frame(8'h05, 8'h00, 2);
    chk({1'b0, r}, 9'h08c);
    chk({8'h0, rx_valid}, 9'h000);
  endtask
  task automatic t_read;
    frame(8'h03, 8'h21, 4);
    chk({1'b0, r}, 9'h06b);
    chk(takes[8:0], 9'h003);
    pop(9'h103);
    pop(9'h021);
    pop(9'h021);
  endtask
  // Junk clocked in while paused must not reach the byte
  task automatic t_pause;
    logic [3:0] hi;
    u_m.cs(1'b0);
    u_m.shift(4, 8'h05, r);
    u_m.pause(1'b0);
    u_m.shift(3, 8'h07, r);
    u_m.pause(1'b1);
    u_m.shift(4, 8'h0b, r);
    u_m.cs(1'b1);
    pop(9'h15b);
    // A pause inside a status read floats the pin and holds the bit
    u_m.cs(1'b0);
    u_m.shift(8, 8'h05, r);
    u_m.shift(4, 8'h00, r);
    hi = r[3:0];
    u_m.pause(1'b0);
    chk({8'h0, so_w}, {8'h0, 1'bz});
    u_m.shift(2, 8'h00, r);
    u_m.pause(1'b1);
    u_m.shift(4, 8'h00, r);
    u_m.cs(1'b1);
    chk({1'b0, hi, r[3:0]}, 9'h08c);
  endtask
  // Ten bytes into eight places while the reader stalls
  task automatic t_fill;
    frame(8'h02, 8'h44, 9);
    chk({8'h0, rx_drop}, 9'h001);
    pop(9'h102);
    for (int k = 0; k < 7; k++) pop(9'h044);
    chk({8'h0, rx_valid}, 9'h000);
    u_m.cs(1'b0);
    chk({8'h0, rx_drop}, 9'h000);
    u_m.cs(1'b1);
  endtask
  // Main sequence
  initial begin
    rst <= 1'b1;
    guard_n <= 1'b1;
    rx_ready <= 1'b0;
    cyc(8);
    rst <= 1'b0;
    cyc(4);
    chk({status, so_oe}, 9'h000);
    u_m.cs(1'b0);
    u_m.cs(1'b1);
    t_desel();
    t_status();
    t_read();
    t_pause();
    t_fill();
    results();
  end
  // Watchdog, several times the expected run
  initial begin
    #500000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
